// ===== rtl/instruction_set_decoder_pkg.sv
package instruction_set_decoder_pkg;

  localparam int CLK_PERIOD_NS         = 8;
  localparam int OSC_PERIODS_PER_CYCLE = 4;
  localparam int AXI_ADDR_W            = 8;

  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] LATCH_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] WORD_OFFSET   = 8'h0c;
  localparam logic [7:0] COUNT_OFFSET  = 8'h10;

  localparam int CTRL_RUN_BIT        = 0;
  localparam int CTRL_PRESC_TMR_BIT  = 1;
  localparam int LATCH_PC_LSB        = 3;
  localparam int STAT_PHASE_LSB      = 0;
  localparam int STAT_NOP_BIT        = 2;
  localparam int STAT_OP_LSB         = 8;

  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] GRP_BYTE    = 2'h0;
  localparam logic [1:0] GRP_BIT     = 2'h1;
  localparam logic [1:0] GRP_BRANCH  = 2'h2;
  localparam logic [1:0] GRP_LITERAL = 2'h3;

  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR  = 4'h1;
  localparam logic [3:0] OP_SUB  = 4'h2;
  localparam logic [3:0] OP_DEC  = 4'h3;
  localparam logic [3:0] OP_IOR  = 4'h4;
  localparam logic [3:0] OP_AND  = 4'h5;
  localparam logic [3:0] OP_XOR  = 4'h6;
  localparam logic [3:0] OP_ADD  = 4'h7;
  localparam logic [3:0] OP_MOV  = 4'h8;
  localparam logic [3:0] OP_COM  = 4'h9;
  localparam logic [3:0] OP_INC  = 4'ha;
  localparam logic [3:0] OP_DSZ  = 4'hb;
  localparam logic [3:0] OP_RRC  = 4'hc;
  localparam logic [3:0] OP_RLC  = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_ISZ  = 4'hf;

  localparam logic [7:0] CODE_RETURN = 8'h08;
  localparam logic [7:0] CODE_INTRET = 8'h09;
  localparam logic [7:0] CODE_SLEEP  = 8'h63;
  localparam logic [7:0] CODE_WDT    = 8'h64;

  typedef enum logic [5:0] {
    no_operation, add_acc_to_file, and_acc_with_file, or_acc_with_file,
    xor_acc_with_file, subtract_acc_from_file, increment_file, decrement_file,
    complement_file, move_file, rotate_left_carry, rotate_right_carry,
    swap_nibbles, decrement_skip_zero, increment_skip_zero, clear_file,
    clear_accumulator, store_acc_to_file, bit_clear_op, bit_set_op,
    test_skip_if_clear, test_skip_if_set, add_literal, and_literal,
    or_literal, xor_literal, subtract_from_literal, load_literal,
    return_with_literal, return_op, interrupt_return, call_op, jump_op,
    watchdog_clear, standby_op
  } op_t;

  typedef enum logic [4:0] {
    alu_none, alu_pass_file, alu_pass_acc, alu_pass_lit, alu_zero, alu_add,
    alu_sub, alu_sub_lit, alu_and, alu_or, alu_xor, alu_com, alu_inc,
    alu_dec, alu_rlc, alu_rrc, alu_swap, alu_bclr, alu_bset, alu_btest
  } alu_t;

  typedef struct packed {
    op_t         op;
    alu_t        alu;
    logic [6:0]  file_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  literal;
    logic [12:0] pc_target;
    logic        write_acc;
    logic        write_file;
    logic        reads_file;
    logic        use_literal;
    logic        upd_c;
    logic        upd_dc;
    logic        upd_z;
    logic        force_z;
    logic        pc_load_lit;
    logic        pc_load_stack;
    logic        stack_push;
    logic        set_gie;
    logic        wdt_clear;
    logic        to_set;
    logic        pd_set;
    logic        pd_clear;
    logic        skip_zero;
    logic        skip_bit_clr;
    logic        skip_bit_set;
    logic        two_cycle;
    logic        prescaler_clear;
    logic        read_pins;
  } ctl_t;

endpackage

// ===== rtl/instruction_set_decoder.sv
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module instruction_set_decoder
  import instruction_set_decoder_pkg::*;
#(
  parameter int         PHASES     = OSC_PERIODS_PER_CYCLE,
  parameter logic [6:0] TIMER_ADDR = 7'h01,
  parameter logic [6:0] PORT0_ADDR = 7'h05,
  parameter logic [6:0] PORT1_ADDR = 7'h06
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Program memory and datapath feedback
  input  wire logic [13:0]       fetch_word,
  input  wire logic              result_zero,
  input  wire logic              tested_bit,
  // Cycle timing
  output logic [1:0]             cycle_phase,
  output logic                   cycle_end,
  output logic                   nop_cycle,
  // Datapath controls
  output op_t                    op_kind,
  output alu_t                   alu_op,
  output logic [6:0]             file_addr,
  output logic [2:0]             bit_sel,
  output logic [7:0]             literal,
  output logic                   use_literal,
  output logic                   write_acc,
  output logic                   write_file,
  output logic                   read_pins,
  // Status flag controls
  output logic                   upd_carry,
  output logic                   upd_half_carry,
  output logic                   upd_zero,
  output logic                   force_zero,
  output logic                   timeout_flag_set,
  output logic                   powerdown_flag_set,
  output logic                   powerdown_flag_clear,
  // Program counter, stack and system
  output logic [12:0]            pc_target,
  output logic                   pc_load_literal,
  output logic                   pc_load_stack,
  output logic                   stack_push,
  output logic                   set_global_interrupt_enable,
  output logic                   watchdog_reset,
  output logic                   prescaler_clear
);

  localparam int PW = (PHASES > 1) ? $clog2(PHASES) : 1;

  if (PHASES != 4) begin : g_check
    $error("instruction_set_decoder: PHASES must be 4");
  end

  logic [PW-1:0] phase_reg;
  logic [1:0]    ctrl_reg;
  logic [7:0]    latch_reg;
  logic [13:0]   word_reg;
  logic [31:0]   count_reg;
  ctl_t          cur_reg;
  ctl_t          dec;
  logic          nop_reg;
  logic          flush;
  logic          run;

  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic                  aw_have_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  w_have_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  logic                  rvalid_reg;
  logic                  do_write;

  function automatic logic hit(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[AXI_ADDR_W-1:2] == off[7:2]);
  endfunction

  function automatic logic is_port(input logic [6:0] a);
    is_port = (a == PORT0_ADDR) || (a == PORT1_ADDR);
  endfunction

  assign run = ctrl_reg[CTRL_RUN_BIT];

  // Decode of the word being fetched; bits marked don't-care are never looked at
  always_comb begin
    dec = '0;
    dec.file_addr = fetch_word[6:0];
    dec.bit_sel   = fetch_word[9:7];
    dec.literal   = fetch_word[7:0];
    dec.pc_target = {latch_reg[LATCH_PC_LSB+1:LATCH_PC_LSB], fetch_word[10:0]};
    case (fetch_word[13:12])
      GRP_BYTE: begin
        case (fetch_word[11:8])
          OP_MISC: begin
            if (fetch_word[7]) begin
              dec.op         = store_acc_to_file;
              dec.alu        = alu_pass_acc;
              dec.write_file = 1'b1;
            end else begin
              case (fetch_word[7:0])
                CODE_RETURN: begin
                  dec.op            = return_op;
                  dec.pc_load_stack = 1'b1;
                  dec.two_cycle     = 1'b1;
                end
                CODE_INTRET: begin
                  dec.op            = interrupt_return;
                  dec.pc_load_stack = 1'b1;
                  dec.set_gie       = 1'b1;
                  dec.two_cycle     = 1'b1;
                end
                CODE_WDT: begin
                  dec.op        = watchdog_clear;
                  dec.wdt_clear = 1'b1;
                  dec.to_set    = 1'b1;
                  dec.pd_set    = 1'b1;
                end
                CODE_SLEEP: begin
                  dec.op        = standby_op;
                  dec.wdt_clear = 1'b1;
                  dec.to_set    = 1'b1;
                  dec.pd_clear  = 1'b1;
                end
                default: dec.op = no_operation;
              endcase
            end
          end
          OP_CLR: begin
            dec.alu     = alu_zero;
            dec.upd_z   = 1'b1;
            dec.force_z = 1'b1;
            if (fetch_word[7]) begin
              dec.op         = clear_file;
              dec.write_file = 1'b1;
            end else begin
              dec.op        = clear_accumulator;
              dec.write_acc = 1'b1;
            end
          end
          default: begin
            dec.reads_file = 1'b1;
            dec.write_file = fetch_word[7];
            dec.write_acc  = ~fetch_word[7];
            dec.upd_z      = 1'b1;
            case (fetch_word[11:8])
              OP_ADD: begin
                dec.op     = add_acc_to_file;
                dec.alu    = alu_add;
                dec.upd_c  = 1'b1;
                dec.upd_dc = 1'b1;
              end
              OP_SUB: begin
                dec.op     = subtract_acc_from_file;
                dec.alu    = alu_sub;
                dec.upd_c  = 1'b1;
                dec.upd_dc = 1'b1;
              end
              OP_AND: begin
                dec.op  = and_acc_with_file;
                dec.alu = alu_and;
              end
              OP_IOR: begin
                dec.op  = or_acc_with_file;
                dec.alu = alu_or;
              end
              OP_XOR: begin
                dec.op  = xor_acc_with_file;
                dec.alu = alu_xor;
              end
              OP_INC: begin
                dec.op  = increment_file;
                dec.alu = alu_inc;
              end
              OP_DEC: begin
                dec.op  = decrement_file;
                dec.alu = alu_dec;
              end
              OP_COM: begin
                dec.op  = complement_file;
                dec.alu = alu_com;
              end
              OP_MOV: begin
                dec.op  = move_file;
                dec.alu = alu_pass_file;
              end
              OP_RLC: begin
                dec.op    = rotate_left_carry;
                dec.alu   = alu_rlc;
                dec.upd_z = 1'b0;
                dec.upd_c = 1'b1;
              end
              OP_RRC: begin
                dec.op    = rotate_right_carry;
                dec.alu   = alu_rrc;
                dec.upd_z = 1'b0;
                dec.upd_c = 1'b1;
              end
              OP_SWAP: begin
                dec.op    = swap_nibbles;
                dec.alu   = alu_swap;
                dec.upd_z = 1'b0;
              end
              OP_DSZ: begin
                dec.op        = decrement_skip_zero;
                dec.alu       = alu_dec;
                dec.upd_z     = 1'b0;
                dec.skip_zero = 1'b1;
              end
              default: begin
                dec.op        = increment_skip_zero;
                dec.alu       = alu_inc;
                dec.upd_z     = 1'b0;
                dec.skip_zero = 1'b1;
              end
            endcase
          end
        endcase
      end
      GRP_BIT: begin
        dec.reads_file = 1'b1;
        case (fetch_word[11:10])
          2'h0: begin
            dec.op         = bit_clear_op;
            dec.alu        = alu_bclr;
            dec.write_file = 1'b1;
          end
          2'h1: begin
            dec.op         = bit_set_op;
            dec.alu        = alu_bset;
            dec.write_file = 1'b1;
          end
          2'h2: begin
            dec.op           = test_skip_if_clear;
            dec.alu          = alu_btest;
            dec.skip_bit_clr = 1'b1;
          end
          default: begin
            dec.op           = test_skip_if_set;
            dec.alu          = alu_btest;
            dec.skip_bit_set = 1'b1;
          end
        endcase
      end
      GRP_BRANCH: begin
        dec.pc_load_lit = 1'b1;
        dec.two_cycle   = 1'b1;
        dec.op          = fetch_word[11] ? jump_op : call_op;
        dec.stack_push  = ~fetch_word[11];
      end
      default: begin
        dec.use_literal = 1'b1;
        dec.write_acc   = 1'b1;
        dec.upd_z       = 1'b1;
        case (fetch_word[11:10])
          2'h0: begin
            dec.op    = load_literal;
            dec.alu   = alu_pass_lit;
            dec.upd_z = 1'b0;
          end
          2'h1: begin
            dec.op            = return_with_literal;
            dec.alu           = alu_pass_lit;
            dec.upd_z         = 1'b0;
            dec.pc_load_stack = 1'b1;
            dec.two_cycle     = 1'b1;
          end
          2'h2: begin
            case (fetch_word[9:8])
              2'h0: begin
                dec.op  = or_literal;
                dec.alu = alu_or;
              end
              2'h1: begin
                dec.op  = and_literal;
                dec.alu = alu_and;
              end
              2'h2: begin
                dec.op  = xor_literal;
                dec.alu = alu_xor;
              end
              default: dec = '0;
            endcase
          end
          default: begin
            dec.op     = fetch_word[9] ? add_literal : subtract_from_literal;
            dec.alu    = fetch_word[9] ? alu_add : alu_sub_lit;
            dec.upd_c  = 1'b1;
            dec.upd_dc = 1'b1;
          end
        endcase
      end
    endcase
    dec.read_pins = dec.reads_file & dec.write_file & is_port(dec.file_addr);
    dec.prescaler_clear = ctrl_reg[CTRL_PRESC_TMR_BIT] & dec.write_file &
                          (dec.file_addr == TIMER_ADDR);
  end

  assign flush = cur_reg.two_cycle |
                 (cur_reg.skip_zero & result_zero) |
                 (cur_reg.skip_bit_clr & ~tested_bit) |
                 (cur_reg.skip_bit_set & tested_bit);

  assign cycle_end = run && (phase_reg == PW'(PHASES - 1));

  // Four clock periods make one instruction cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= cycle_end ? '0 : phase_reg + PW'(1);
    end
  end

  // The next word is taken at the end of each cycle, or replaced by a nop cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cur_reg  <= '0;
      nop_reg  <= 1'b0;
      word_reg <= 14'h0000;
    end else if (cycle_end) begin
      if (flush) begin
        cur_reg <= '0;
        nop_reg <= 1'b1;
      end else begin
        cur_reg  <= dec;
        nop_reg  <= 1'b0;
        word_reg <= fetch_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h0000_0000;
    end else if (cycle_end) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  assign awready  = !aw_have_reg && !bvalid_reg;
  assign wready   = !w_have_reg && !bvalid_reg;
  assign arready  = !rvalid_reg;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (hit(aw_addr_reg, CTRL_OFFSET) || hit(aw_addr_reg, LATCH_OFFSET) ||
                        hit(aw_addr_reg, STATUS_OFFSET) || hit(aw_addr_reg, WORD_OFFSET) ||
                        hit(aw_addr_reg, COUNT_OFFSET)) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= CTRL_RESET;
      latch_reg <= LATCH_RESET;
    end else if (do_write && w_strb_reg[0]) begin
      if (hit(aw_addr_reg, CTRL_OFFSET)) begin
        ctrl_reg <= w_data_reg[1:0];
      end
      if (hit(aw_addr_reg, LATCH_OFFSET)) begin
        latch_reg <= w_data_reg[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      if (hit(araddr, CTRL_OFFSET)) begin
        rdata_reg[1:0] <= ctrl_reg;
      end else if (hit(araddr, LATCH_OFFSET)) begin
        rdata_reg[7:0] <= latch_reg;
      end else if (hit(araddr, STATUS_OFFSET)) begin
        rdata_reg[STAT_PHASE_LSB+1:STAT_PHASE_LSB] <= phase_reg;
        rdata_reg[STAT_NOP_BIT]                    <= nop_reg;
        rdata_reg[STAT_OP_LSB+5:STAT_OP_LSB]       <= cur_reg.op;
      end else if (hit(araddr, WORD_OFFSET)) begin
        rdata_reg[13:0] <= word_reg;
      end else if (hit(araddr, COUNT_OFFSET)) begin
        rdata_reg <= count_reg;
      end else begin
        rresp_reg <= RESP_SLVERR;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;

  assign cycle_phase                 = phase_reg;
  assign nop_cycle                   = nop_reg;
  assign op_kind                     = cur_reg.op;
  assign alu_op                      = cur_reg.alu;
  assign file_addr                   = cur_reg.file_addr;
  assign bit_sel                     = cur_reg.bit_sel;
  assign literal                     = cur_reg.literal;
  assign use_literal                 = cur_reg.use_literal;
  assign write_acc                   = cur_reg.write_acc;
  assign write_file                  = cur_reg.write_file;
  assign read_pins                   = cur_reg.read_pins;
  assign upd_carry                   = cur_reg.upd_c;
  assign upd_half_carry              = cur_reg.upd_dc;
  assign upd_zero                    = cur_reg.upd_z;
  assign force_zero                  = cur_reg.force_z;
  assign timeout_flag_set            = cur_reg.to_set;
  assign powerdown_flag_set          = cur_reg.pd_set;
  assign powerdown_flag_clear        = cur_reg.pd_clear;
  assign pc_target                   = cur_reg.pc_target;
  assign pc_load_literal             = cur_reg.pc_load_lit;
  assign pc_load_stack               = cur_reg.pc_load_stack;
  assign stack_push                  = cur_reg.stack_push;
  assign set_global_interrupt_enable = cur_reg.set_gie;
  assign watchdog_reset              = cur_reg.wdt_clear;
  assign prescaler_clear             = cur_reg.prescaler_clear;

endmodule // instruction_set_decoder

// ===== tb/prog_mem.sv
`timescale 1ns/1ns
module prog_mem (
  // Clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // Fetch side
  input  logic        cycle_end,
  output logic [13:0] fetch_word,
  output logic        result_zero,
  output logic        tested_bit
);
  // Entry: result_zero, tested_bit, word; the flags judge the op before it
  localparam logic [15:0] ROM [16] = '{16'h0785, 16'h3f55, 16'h2123, 16'h3fff,
    16'h0b01, 16'hbfff, 16'h1c85, 16'h0064, 16'h0063, 16'h1805, 16'h3fff, 16'h0d05,
    16'h0181, 16'h0009, 16'h3fff, 16'h3405};
  logic [3:0] idx_reg;
  // Fetch advances every cycle until it holds at the last entry, so words behind a skip or branch are lost
  always_ff @(posedge aclk) begin
    if (!aresetn) idx_reg <= 4'h0;
    else if (cycle_end && idx_reg != 4'hf) idx_reg <= idx_reg + 4'h1;
  end
  assign {result_zero, tested_bit, fetch_word} = ROM[idx_reg];
endmodule // prog_mem

// ===== tb/instruction_set_decoder_monitor.sv
`timescale 1ns/1ns
module decoder_monitor import instruction_set_decoder_pkg::*; (
  // Watched ports
  input logic        aclk,
  input logic        aresetn,
  input logic [13:0] fetch_word,
  input logic        result_zero,
  input logic [1:0]  cycle_phase,
  input logic        cycle_end,
  input logic        nop_cycle,
  input op_t         op_kind,
  input logic [6:0]  file_addr,
  input logic [2:0]  bit_sel,
  input logic        write_acc,
  input logic        write_file,
  input logic        timeout_flag_set,
  input logic        powerdown_flag_set,
  input logic [12:0] pc_target,
  input logic        pc_load_literal
);
  logic [13:0] w_reg;
  always_ff @(posedge aclk) w_reg <= fetch_word;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_nop;
    (nop_cycle && op_kind == no_operation) [*4];
  endsequence
  a_phase_walk: assert property (
    cycle_end |-> cycle_phase == 2'h3 ##1 cycle_phase == 2'h0 ##1 cycle_phase == 2'h1)
    else $error("phase walk");
  a_ctl_hold: assert property (cycle_phase != 2'h0 |-> $stable(op_kind))
    else $error("control changed mid cycle");
  a_dest_select: assert property (cycle_end && fetch_word[13:8] == 6'h07 |=> nop_cycle ||
    (op_kind == add_acc_to_file && write_file == w_reg[7] && write_acc == !w_reg[7]))
    else $error("destination select");
  a_bit_fields: assert property (cycle_end && fetch_word[13:12] == 2'h1 |=> nop_cycle ||
    (file_addr == w_reg[6:0] && bit_sel == w_reg[9:7]))
    else $error("bit fields");
  a_branch_target: assert property (cycle_end && fetch_word[13:12] == 2'h2 |=> nop_cycle ||
    (pc_load_literal && pc_target[10:0] == w_reg[10:0]))
    else $error("branch target");
  a_skip_nop: assert property (
    cycle_end && op_kind == decrement_skip_zero && result_zero |=> s_nop)
    else $error("skip nop");
  a_branch_nop: assert property (cycle_end && pc_load_literal |=> s_nop)
    else $error("branch nop");
  a_wdt_flags: assert property (op_kind == watchdog_clear |-> timeout_flag_set && powerdown_flag_set)
    else $error("watchdog flags");
endmodule // decoder_monitor
bind instruction_set_decoder decoder_monitor mon_u (.*);

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top import instruction_set_decoder_pkg::*;;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic        arready, rvalid, rready, result_zero, tested_bit, cycle_end, nop_cycle;
  logic        use_literal, write_acc, write_file, read_pins, upd_carry, upd_half_carry;
  logic        upd_zero, force_zero, timeout_flag_set, powerdown_flag_set, powerdown_flag_clear;
  logic        pc_load_literal, pc_load_stack, stack_push, set_global_interrupt_enable;
  logic        watchdog_reset, prescaler_clear;
  logic [7:0]  awaddr, araddr, literal;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, cycle_phase;
  logic [13:0] fetch_word;
  logic [12:0] pc_target;
  logic [6:0]  file_addr;
  logic [2:0]  bit_sel;
  op_t         op_kind;
  alu_t        alu_op;
  int          err_count, samples_checked;
  instruction_set_decoder dut_u (.*);
  prog_mem pm_u (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo();
    chk(1'b0, "timeout");
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 20; n++) begin
      @(negedge aclk);
      {ha, hw, hb, r} = {awready, wready, bvalid, bresp};
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    chk(r === RESP_OKAY, "write response");
    if (n == 20) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ha, hr;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 20; n++) begin
      @(negedge aclk);
      {ha, hr, d, r} = {arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
    if (n == 20) tmo();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(CTRL_OFFSET, d, r);
    chk(d === 32'h0 && r === RESP_OKAY, "control reset value");
    rd(8'h40, d, r);
    chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
    wr(LATCH_OFFSET, 32'h18);
    rd(LATCH_OFFSET, d, r);
    chk(d === 32'h18, "latch readback");
  endtask
  // Flushed words run as nop in cycles 4, 6, 11 and 15
  task automatic t_run();
    op_t exp [17] = '{no_operation, add_acc_to_file, add_literal, call_op, no_operation,
      decrement_skip_zero, no_operation, test_skip_if_set, watchdog_clear, standby_op,
      test_skip_if_clear, no_operation, rotate_left_carry, clear_file, interrupt_return,
      no_operation, return_with_literal};
    int n;
    wr(CTRL_OFFSET, 32'h3);
    @(negedge aclk);
    for (int k = 1; k < 17; k++) begin
      for (n = 0; n < 9 && cycle_end !== 1'b1; n++) @(negedge aclk);
      if (n == 9) tmo();
      @(negedge aclk);
      chk(op_kind === exp[k] && nop_cycle === (k inside {4, 6, 11, 15}), "decode");
      if (k == 1) chk(write_file === 1'b1 && read_pins === 1'b1, "port dest");
      if (k == 1) chk({upd_carry, upd_half_carry, upd_zero} === 3'h7, "add");
      if (k == 2) chk({use_literal, write_acc, literal} === 10'h355, "literal");
      if (k == 3) chk(pc_target === 13'h1923 && stack_push === 1'b1, "call target");
      if (k == 5) chk({write_acc, upd_zero} === 2'h2, "skip op");
      if (k == 8) chk(timeout_flag_set === 1'b1 && powerdown_flag_set === 1'b1, "wdt");
      if (k == 8) chk(watchdog_reset === 1'b1, "wdt reset");
      if (k == 9) chk({timeout_flag_set, powerdown_flag_clear} === 2'h3, "stby");
      if (k == 12) chk({upd_carry, upd_zero, write_acc} === 3'h5, "rlc");
      if (k == 13) chk({write_file, force_zero, prescaler_clear} === 3'h7, "clr");
      if (k == 14) chk({pc_load_stack, set_global_interrupt_enable} === 2'h3, "ret");
      if (k == 16) chk({pc_load_stack, write_acc, literal} === 10'h305, "return_with_literal");
    end
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_run();
    final_report();
  end
endmodule // tb_top
